// *** verilog/onoff_pkg.sv ***
/*
 * onoff_pkg: constants, carrier structs and state types for the on/off
 * switch controller.
 * Assumes a 200 MHz core clock; all pin inputs arrive asynchronously.
 */
`default_nettype none

package onoff_pkg;

    // ==========================================================
    // clock and oscillator timing
    // ==========================================================
    localparam int CLK_HZ    = 200_000_000;
    localparam int OSC_HZ    = 132_000;      // average switching rate
    localparam int JIT_HZ    = 4_000;        // jitter deviation
    localparam int SWEEP_HZ  = 1_000;        // jitter sweep rate
    localparam int DMAX_PCT  = 65;           // max duty, percent
    localparam int PERIOD_CYC = CLK_HZ / OSC_HZ;
    localparam int JIT_CYC   = CLK_HZ / (OSC_HZ - JIT_HZ) - PERIOD_CYC;
    localparam int SWEEP_CYC = CLK_HZ / SWEEP_HZ / 2;   // half sweep
    localparam int DMAX_CYC  = PERIOD_CYC * DMAX_PCT / 100;
    localparam int OSC_W     = 12;

    // ==========================================================
    // fault timer and auto-restart, counted in oscillator cycles
    // ==========================================================
    localparam int FAULT_MS  = 64;
    localparam int OFF_MS    = 2500;
    localparam int FAULT_OSC = FAULT_MS * (OSC_HZ / 1000);
    localparam int OFF_OSC   = OFF_MS * (OSC_HZ / 1000);
    localparam int TMR_W     = 20;

    // ==========================================================
    // current limit stepping and thermal figures
    // ==========================================================
    localparam int     STEP_RUN     = 4;     // identical samples per step
    localparam int     RUN_W        = 3;
    localparam int     THERM_TRIP_C = 142;   // comparator trip, deg C
    localparam int     THERM_HYST_C = 75;    // comparator hysteresis
    localparam logic [1:0] ILIM_LOW  = 2'h0;
    localparam logic [1:0] ILIM_MID  = 2'h1;
    localparam logic [1:0] ILIM_HIGH = 2'h2;

    typedef enum logic [1:0] {LIM_LOW, LIM_MID, LIM_HIGH} lim_state_t;
    typedef enum logic [1:0] {AR_RUN, AR_OFF, AR_UV_HOLD} ar_state_t;

    // asynchronous sense inputs from the analogue front end
    typedef struct packed {
        logic en_pulled_low;   // feedback draws above threshold
        logic cur_limit_hit;   // transistor current at selected limit
        logic line_uv;         // line undervoltage present
        logic temp_trip;       // die above trip point
        logic temp_release;    // die below trip minus hysteresis
    } sense_t;

    // control and status outputs
    typedef struct packed {
        logic       gate_on;
        logic       cycle_start;
        logic       max_duty_signal;
        logic [1:0] ilim_sel;
        logic       restart_off;
        logic       therm_off;
        logic       ote_en;
    } ctl_out_t;

endpackage

`default_nettype wire

// *** verilog/onoff_switch_control.sv ***
/*
 * onoff_switch_control: cycle-by-cycle on/off controller for the power
 * transistor, with jittered oscillator, current limit state machine,
 * auto-restart fault timer, on-time extension gate and thermal latch.
 * Assumes sense inputs come from asynchronous comparators and the gate
 * output drives a transistor driver; there is no software access.
 */
//
// Function
// - the cycle clock runs always and each cycle start samples enable.
// - the current limit level steps from the pattern of enable samples.
// - an enabled pulse lasts until the selected limit; skips regulate.
// - a fault timer on oscillator cycles clears whenever enable is low.
// - 64 ms without enable low blocks switching for 2.5 s.
// - expiry under line undervoltage blocks until that condition ends.
// - a persisting fault alternates enabled and blocked periods.
// - on-time extension stays off until enable has been pulled low.
// - switching stops above the trip temperature until 75 C cooler.
// - the oscillator averages 132 kHz with cycle start and max duty.
// - the switching frequency is jittered with a 1 kHz sweep.
// - switching stops while enable is pulled low, resumes after.
`timescale 1ns/1ps
`default_nettype none

module onoff_switch_control #(
    parameter int FAULT_CYC = onoff_pkg::FAULT_OSC,
    parameter int OFF_CYC   = onoff_pkg::OFF_OSC,
    parameter int SWEEP_LEN = onoff_pkg::SWEEP_CYC
) (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire onoff_pkg::sense_t sense,
    output var  onoff_pkg::ctl_out_t ctl
);
    import onoff_pkg::*;

    // ==========================================================
    // input synchronisers
    // ==========================================================
    sense_t sync_a;
    sense_t sense_s;

    // two flops per comparator; only the second stage is read
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            sync_a  <= '0;
            sense_s <= '0;
        end
        else
        begin
            sync_a  <= sense;
            sense_s <= sync_a;
        end
    end

    // ==========================================================
    // jittered oscillator
    // ==========================================================
    logic [OSC_W-1:0] osc_cnt, next_osc_cnt;
    logic [OSC_W-1:0] jit_ofs, next_jit_ofs;  // offset above the minimum
    logic             jit_up, next_jit_up;
    logic [17:0]      sweep_cnt, next_sweep_cnt;
    logic             cyc_end;
    logic [OSC_W-1:0] period_min;

    assign period_min = OSC_W'(PERIOD_CYC - JIT_CYC);
    assign cyc_end    = (osc_cnt >= period_min + jit_ofs);

    // the offset ramps one clock per cycle and the ramp direction flips
    // every half sweep, so the period wanders around its average
    always_comb
    begin
        next_osc_cnt   = cyc_end ? '0 : osc_cnt + 1'b1;
        next_sweep_cnt = sweep_cnt + 1'b1;
        next_jit_up    = jit_up;
        next_jit_ofs   = jit_ofs;
        if (sweep_cnt >= 18'(SWEEP_LEN - 1))
        begin
            next_sweep_cnt = '0;
            next_jit_up    = !jit_up;
        end
        if (cyc_end)
        begin
            if (jit_up && jit_ofs < OSC_W'(2 * JIT_CYC))
                next_jit_ofs = jit_ofs + 1'b1;
            else if (!jit_up && jit_ofs != '0)
                next_jit_ofs = jit_ofs - 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            osc_cnt   <= '0;
            jit_ofs   <= OSC_W'(JIT_CYC);
            jit_up    <= 1'b1;
            sweep_cnt <= '0;
        end
        else
        begin
            osc_cnt   <= next_osc_cnt;
            jit_ofs   <= next_jit_ofs;
            jit_up    <= next_jit_up;
            sweep_cnt <= next_sweep_cnt;
        end
    end

    logic cyc_start, in_dmax;
    assign cyc_start = (osc_cnt == '0);
    assign in_dmax   = (osc_cnt < OSC_W'(DMAX_CYC));

    // ==========================================================
    // protection: auto-restart and thermal latch
    // ==========================================================
    ar_state_t        ar, next_ar;
    logic [TMR_W-1:0] tmr, next_tmr;
    logic             therm, next_therm;

    // timer advances once per oscillator cycle; enable low clears it
    always_comb
    begin
        next_ar  = ar;
        next_tmr = tmr;
        case (ar)
            AR_RUN:
            begin
                if (sense_s.en_pulled_low)
                    next_tmr = '0;
                else if (cyc_start)
                begin
                    if (tmr >= TMR_W'(FAULT_CYC - 1))
                    begin
                        next_tmr = '0;
                        next_ar  = sense_s.line_uv ? AR_UV_HOLD
                                                   : AR_OFF;
                    end
                    else
                        next_tmr = tmr + 1'b1;
                end
            end
            AR_OFF:
            begin
                if (cyc_start)
                begin
                    if (tmr >= TMR_W'(OFF_CYC - 1))
                    begin
                        next_tmr = '0;
                        next_ar  = AR_RUN;
                    end
                    else
                        next_tmr = tmr + 1'b1;
                end
            end
            AR_UV_HOLD:
            begin
                next_tmr = '0;
                if (!sense_s.line_uv)
                    next_ar = AR_RUN;
            end
            default:
            begin
                next_ar  = AR_RUN;
                next_tmr = '0;
            end
        endcase
        // trip sets and wins over the release level if both are seen
        if (sense_s.temp_trip)
            next_therm = 1'b1;
        else if (sense_s.temp_release)
            next_therm = 1'b0;
        else
            next_therm = therm;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            ar    <= AR_RUN;
            tmr   <= '0;
            therm <= 1'b0;
        end
        else
        begin
            ar    <= next_ar;
            tmr   <= next_tmr;
            therm <= next_therm;
        end
    end

    // ==========================================================
    // cycle sampling, current limit state machine, gate drive
    // ==========================================================
    lim_state_t     lim, next_lim;
    logic [RUN_W-1:0] run, next_run;
    logic           run_on, next_run_on;   // polarity of the current run
    logic           gate, next_gate;
    logic           ote, next_ote;
    logic           blocked, cyc_en;

    assign blocked = (ar != AR_RUN) || therm;
    assign cyc_en  = !sense_s.en_pulled_low && !blocked;

    // limit steps up after a run of enabled cycles and down after a run
    // of skipped ones; single-cycle dither does not move it
    always_comb
    begin
        next_lim    = lim;
        next_run    = run;
        next_run_on = run_on;
        next_gate   = gate;
        next_ote    = ote;
        if (sense_s.en_pulled_low)
            next_ote = 1'b1;
        if (cyc_start)
        begin
            next_gate = cyc_en && (next_ar == AR_RUN);
            if (cyc_en != run_on)
            begin
                next_run_on = cyc_en;
                next_run    = RUN_W'(1);
            end
            else if (run >= RUN_W'(STEP_RUN - 1))
            begin
                next_run = '0;
                case (lim)
                    LIM_LOW:  next_lim = cyc_en ? LIM_MID : LIM_LOW;
                    LIM_MID:  next_lim = cyc_en ? LIM_HIGH : LIM_LOW;
                    LIM_HIGH: next_lim = cyc_en ? LIM_HIGH : LIM_MID;
                    default:  next_lim = LIM_HIGH;
                endcase
            end
            else
                next_run = run + 1'b1;
        end
        else if (gate)
        begin
            // extension lets a low-line pulse run past max duty
            if (sense_s.cur_limit_hit)
                next_gate = 1'b0;
            else if (!in_dmax && !ote)
                next_gate = 1'b0;
            else if (blocked || cyc_end)
                next_gate = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            lim    <= LIM_HIGH;
            run    <= '0;
            run_on <= 1'b1;
            gate   <= 1'b0;
            ote    <= 1'b0;
        end
        else
        begin
            lim    <= next_lim;
            run    <= next_run;
            run_on <= next_run_on;
            gate   <= next_gate;
            ote    <= next_ote;
        end
    end

    // ==========================================================
    // outputs
    // ==========================================================
    always_comb
    begin
        ctl.gate_on         = gate;
        ctl.cycle_start     = cyc_start;
        ctl.max_duty_signal = in_dmax;
        case (lim)
            LIM_LOW:  ctl.ilim_sel = ILIM_LOW;
            LIM_MID:  ctl.ilim_sel = ILIM_MID;
            default:  ctl.ilim_sel = ILIM_HIGH;
        endcase
        ctl.restart_off     = (ar != AR_RUN);
        ctl.therm_off       = therm;
        ctl.ote_en          = ote;
    end

endmodule

`default_nettype wire

// *** bench/onoff_monitor.sv ***
/* onoff_monitor: port assertions for the on/off switch controller.
   Assumes a bind onto onoff_switch_control and 2-flop input sync. */
`timescale 1ns/1ps
`default_nettype none
module onoff_monitor (
    input wire logic                clk,
    input wire logic                rstn,
    input wire onoff_pkg::sense_t   sense,
    input wire onoff_pkg::ctl_out_t ctl
);
    import onoff_pkg::*;
    // ====================
    // cycle tracker
    // ====================
    logic [11:0] cnt;
    logic [11:0] next_cnt;
    logic        seen;
    logic        next_seen;
    // seen masks the first start after reset, whose period is unknown
    always_comb
    begin
        next_cnt = ctl.cycle_start ? 12'h000 : cnt + 12'h001;
        next_seen = seen | ctl.cycle_start;
    end
    always_ff @(posedge clk)
    begin
        cnt <= rstn ? next_cnt : 12'h000;
        seen <= rstn & next_seen;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_rise; $rose(ctl.gate_on); endsequence
    sequence s_hit; sense.cur_limit_hit [*3]; endsequence
    sequence s_low_start; sense.en_pulled_low [*4] ##0 ctl.cycle_start;
    endsequence
    // ====================
    // assertions
    // ====================
    a_gate_after_start: assert property (s_rise |-> $past(ctl.cycle_start))
        else $error("gate rose away from a cycle start");
    a_skip_when_low: assert property (s_low_start |=> !ctl.gate_on)
        else $error("pulse in a cycle sampled low");
    a_limit_ends_pulse: assert property (
        s_hit ##0 !ctl.cycle_start |=> !ctl.gate_on)
        else $error("pulse kept on past the limit");
    a_expiry_no_pulse: assert property (
        $rose(ctl.restart_off) |-> !ctl.gate_on)
        else $error("pulse started at fault timer expiry");
    a_duty_ends_pulse: assert property (
        (!ctl.max_duty_signal && !ctl.ote_en) [*2] |-> !ctl.gate_on)
        else $error("pulse kept on past max duty");
    a_duty_width: assert property (!ctl.cycle_start |->
        ctl.max_duty_signal == (cnt < 12'(DMAX_CYC - 1)))
        else $error("max duty window wrong");
    a_period_range: assert property (ctl.cycle_start && seen |->
        cnt inside {[12'h5BC:12'h61A]})
        else $error("cycle period out of range");
    a_restart_blocks: assert property (ctl.restart_off [*2] |-> !ctl.gate_on)
        else $error("switching during auto-restart");
    a_therm_blocks: assert property (ctl.therm_off [*2] |-> !ctl.gate_on)
        else $error("switching while too hot");
    a_therm_trips: assert property (sense.temp_trip [*3] |=> ctl.therm_off)
        else $error("thermal latch did not set");
    a_ote_sticky: assert property (ctl.ote_en |=> ctl.ote_en)
        else $error("on-time extension dropped");
endmodule
bind onoff_switch_control onoff_monitor mon_u (
    .clk   (clk),
    .rstn  (rstn),
    .sense (sense),
    .ctl   (ctl)
);
`default_nettype wire

// *** bench/feedback_model.sv ***
/* feedback_model: optocoupler network that pulls the enable input.
   Assumes the bench sets the pull level; LAG sets its response time. */
`timescale 1ns/1ps
`default_nettype none
module feedback_model #(
    parameter int LAG = 1
) (
    input  wire logic clk,
    input  wire logic pull,
    output var  logic en_low
);
    // a slow opto transistor is modelled as a plain delay line
    logic [7:0] pipe;
    always_ff @(posedge clk)
    begin
        pipe <= {pipe[6:0], pull};
    end
    assign en_low = pipe[LAG];
endmodule
`default_nettype wire

// *** bench/tb.sv ***
/* tb: self-checking bench for the on/off switch controller.
   Assumes onoff_pkg, the feedback model and the bound monitor. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import onoff_pkg::*;
    typedef struct {logic pull; int n; logic [1:0] lim;} row_t;
    localparam int FCYC = 6;
    localparam int OCYC = 3;
    // ====================
    // signals
    // ====================
    logic     clk = 1'h0, rstn = 1'h0, pull = 1'h0, lim_on = 1'h0;
    logic     uv = 1'h0, trip = 1'h0, rel = 1'h0, ro_seen = 1'h0;
    logic     en_low;
    logic     hit;
    sense_t   sense;
    ctl_out_t ctl;
    int       bad_count = 0;
    int       comparisons = 0;
    int       pulses = 0;
    int       on_clks = 0;
    int       k;
    // skipped runs step the limit down, enabled runs step it up
    row_t     rows [5] = '{'{1'h1, 4, ILIM_MID}, '{1'h0, 4, ILIM_HIGH},
        '{1'h1, 4, ILIM_MID}, '{1'h1, 4, ILIM_LOW}, '{1'h0, 4, ILIM_MID}};
    assign hit = lim_on && on_clks > 100;
    assign sense = '{en_low, hit, uv, trip, rel};
    initial forever #2.5 clk = ~clk;
    // current ramp seen by the limit comparator, plus pulse bookkeeping
    always @(posedge clk)
    begin
        on_clks <= ctl.gate_on ? on_clks + 1 : 0;
        if (on_clks == 1)
            pulses <= pulses + 1;
        if (ctl.restart_off === 1'h1)
            ro_seen <= 1'h1;
    end
    onoff_switch_control #(
        .FAULT_CYC (FCYC),
        .OFF_CYC   (OCYC),
        .SWEEP_LEN (50)
    ) dut_u (
        .clk   (clk),
        .rstn  (rstn),
        .sense (sense),
        .ctl   (ctl)
    );
    feedback_model #(.LAG(1)) opto_u (.clk(clk), .pull(pull), .en_low(en_low));
    // ====================
    // tasks
    // ====================
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask
    task automatic results;
        if (bad_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic timeout;
        check(8'h00, 8'h01);
        results();
    endtask
    // waits for n cycle starts, then lets the sample settle
    task automatic step(input int n);
        int t;
        repeat (n)
        begin
            t = 0;
            do
            begin
                @(negedge clk);
                t++;
            end
            while (ctl.cycle_start !== 1'h1 && t < 2000);
            if (t >= 2000)
                timeout();
            repeat (4) @(negedge clk);
        end
    endtask
    task automatic wait_ro(input logic lvl, output int n);
        n = 0;
        while (ctl.restart_off !== lvl && n < 12)
        begin
            step(1);
            n++;
        end
        if (n == 12)
            timeout();
    endtask
    // ====================
    // main sequence
    // ====================
    initial
    begin
        repeat (4) @(negedge clk);
        check(8'(ctl), 8'h70);
        rstn = 1'h1;
        step(2);
        check(8'(ctl.ote_en), 8'h00);
        lim_on = 1'h1;
        foreach (rows[i])
        begin
            pull = rows[i].pull;
            k = pulses;
            step(rows[i].n);
            check(8'(ctl.ilim_sel), 8'(rows[i].lim));
            check(8'(pulses - k), 8'(pull ? 0 : rows[i].n));
        end
        check(8'(ctl.ote_en), 8'h01);
        check(8'(ro_seen), 8'h00);
        // overload: one pulled cycle, then no pull until the fault timer runs out
        pull = 1'h1;
        step(1);
        pull = 1'h0;
        wait_ro(1'h1, k);
        check(8'(k >= FCYC - 1 && k <= FCYC + 1), 8'h01);
        wait_ro(1'h0, k);
        check(8'(k >= OCYC && k <= OCYC + 1), 8'h01);
        k = pulses;
        step(2);
        check(8'(pulses - k > 0), 8'h01);
        // expiry under line undervoltage holds off past the fixed period
        pull = 1'h1;
        step(1);
        pull = 1'h0;
        uv = 1'h1;
        wait_ro(1'h1, k);
        step(OCYC + 2);
        check(8'(ctl.restart_off), 8'h01);
        uv = 1'h0;
        pull = 1'h1;
        step(1);
        check(8'(ctl.restart_off), 8'h00);
        pull = 1'h0;
        // thermal trip, then release through the cold comparator
        trip = 1'h1;
        repeat (3) @(negedge clk);
        trip = 1'h0;
        k = pulses;
        step(2);
        check(8'(pulses - k), 8'h00);
        rel = 1'h1;
        repeat (3) @(negedge clk);
        rel = 1'h0;
        step(1);
        check(8'(ctl.therm_off), 8'h00);
        k = pulses;
        step(2);
        check(8'(pulses - k > 0), 8'h01);
        results();
    end
endmodule
`default_nettype wire
